// ### rtl/mss_defs.vh
// Register map, field positions, reset values and widths for the switch sensor bank
`ifndef MSS_DEFS_VH
`define MSS_DEFS_VH

// Register addresses
`define MSS_ADDR_ID 8'h00
`define MSS_ADDR_FLAG 8'h10
`define MSS_ADDR_SUM 8'h18
`define MSS_ADDR_DATA_LAST 8'h1F
`define MSS_ADDR_IRQCFG 8'h20
`define MSS_ADDR_OPCFG 8'h21
`define MSS_ADDR_THR_FIRST 8'h22
`define MSS_ADDR_SET_LAST 8'h25
`define MSS_ADDR_SOFT_RESET_BYTE 8'h30
`define MSS_ADDR_FACT_A 8'h40
`define MSS_ADDR_FACT_B 8'h41

// Flag byte layout
`define MSS_FLAG_ONE 7
`define MSS_FLAG_OVR 6
`define MSS_FLAG_ERR 5
`define MSS_FLAG_SUM 4
`define MSS_FLAG_Z 3
`define MSS_FLAG_Y 2
`define MSS_FLAG_X 1
`define MSS_FLAG_RDY 0

// Interrupt configuration word layout
`define MSS_IRQ_EN_MSB 5
`define MSS_POL_X 8
`define MSS_POL_Y 9
`define MSS_POL_Z 10
`define MSS_POL_SUM 11
`define MSS_IRQCFG_MASK 16'h0F3F

// Soft reset bit
`define MSS_SOFT_RESET_BYTE_BIT 0

// Reset values
`define MSS_FLAG_RESET 8'h80
`define MSS_IRQCFG_RESET 16'h0000
`define MSS_OPCFG_RESET 8'h00
`define MSS_THR_RESET 16'h0000
`define MSS_RSV_VALUE 16'h0000

// Burst index limit
`define MSS_IDX_MAX 3'h7

`endif

// ### rtl/mss_hyst.v
// Hysteresis switch flag for one measured quantity
`timescale 1ns/10ps
`default_nettype none

module mss_hyst (
  // Clock, reset, enable
  input wire mclk_i,
  input wire nrst_i,
  input wire ce_i,
  // Control
  input wire clr_i,
  input wire upd_i,
  input wire sgn_i,
  input wire pol_i,
  // Data and levels
  input wire [31:0] val_i,
  input wire [15:0] op_lvl_i,
  input wire [15:0] rel_lvl_i,
  // Result
  output reg flag_o
);

  wire signed [32:0] val_ext;
  wire signed [32:0] op_ext;
  wire signed [32:0] rel_ext;
  reg next_flag;

  // Axes are signed words; the sum of squares is unsigned
  assign val_ext = sgn_i ? {{17{val_i[15]}}, val_i[15:0]} : {1'b0, val_i};
  assign op_ext = sgn_i ? {{17{op_lvl_i[15]}}, op_lvl_i} : {17'h00000, op_lvl_i};
  assign rel_ext = sgn_i ? {{17{rel_lvl_i[15]}}, rel_lvl_i} : {17'h00000, rel_lvl_i};

  // Between the two levels the flag keeps its state
  always @*
  begin
    next_flag = flag_o;
    if (!pol_i)
    begin
      if (val_ext > op_ext)
        next_flag = 1'b1;
      else if (val_ext < rel_ext)
        next_flag = 1'b0;
    end
    else
    begin
      if (val_ext < op_ext)
        next_flag = 1'b1;
      else if (val_ext > rel_ext)
        next_flag = 1'b0;
    end
  end

  // Flag only moves when a result lands or clr_i clears it
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      flag_o <= 1'b0;
    else if (ce_i)
    begin
      if (clr_i)
        flag_o <= 1'b0;
      else if (upd_i)
        flag_o <= next_flag;
    end
  end

endmodule

`default_nettype wire

// ### rtl/mss_regbank.v
// Register bank of the three-axis magnetic switch sensor, byte-serial host side
`timescale 1ns/10ps
`default_nettype none
`include "mss_defs.vh"

// Functional notes
// - The low byte of the identification word at address 00h is a fixed device code.
// - The high byte of the identification word at address 00h is a fixed maker code.
// - Every address 10h to 1Fh returns the flag byte first: bit 7 one, then overrun, overflow, sum, Z, Y, X and data ready.
// - Data ready goes to one whenever a new measurement result lands.
// - Data ready clears when a data register is read to its last byte or a setting register 20h-25h is accessed.
// - Overrun goes to one when a result is replaced before the host read it.
// - Overrun clears once the data has been read and the following measurement has completed, or on a soft reset.
// - Each switch flag sets above its operate level and clears below its release level, or the reverse when its polarity bit is set.
// - The overflow flag shows whether the latest measurement overflowed.
// - Bursts within 20h-25h advance the address and wrap from 25h back to 20h.
// - Axis data are 16-bit two's complement words sent high byte first.
module mss_regbank #(
  parameter [7:0] DEV_CODE = 8'h5A, // Arbitrary value
  parameter [7:0] MAKER_CODE = 8'hA5 // Arbitrary value
) (
  // Clock, reset and enable
  input wire mclk_i,
  input wire nrst_i,
  input wire ce_i,
  // Host byte access
  input wire acc_start_i,
  input wire [7:0] acc_addr_i,
  input wire rd_req_i,
  input wire wr_req_i,
  input wire [7:0] wr_data_i,
  // Measurement engine results
  input wire meas_done_i,
  input wire meas_ovf_i,
  input wire [15:0] meas_x_i,
  input wire [15:0] meas_y_i,
  input wire [15:0] meas_z_i,
  input wire [31:0] meas_sum_i,
  // Host read answer
  output reg rd_valid_o,
  output reg [7:0] rd_data_o,
  // Configuration and event
  output reg [7:0] op_cfg_o,
  output reg soft_reset_byte_o,
  output reg evt_o
);

  reg [7:0] ptr;
  reg [2:0] idx;
  reg rdy_flag;
  reg ovr_flag;
  reg err_flag;
  reg read_seen;
  reg [15:0] irq_cfg;
  reg [15:0] thr [0:7];
  reg [15:0] x_data;
  reg [15:0] y_data;
  reg [15:0] z_data;
  reg [31:0] sum_data;
  reg [7:0] next_byte;
  wire sw_x;
  wire sw_y;
  wire sw_z;
  wire sw_sum;
  wire [7:0] flag_byte;
  wire [2:0] cur_len;
  wire in_set;
  wire in_data;
  wire step;
  wire last_byte;
  wire data_read_done;
  wire set_touch;
  wire [2:0] thr_sel;
  wire [15:0] rsv_word;
  wire [15:0] irq_mask;
  integer k;

  // Byte count of the register at each address
  function [2:0] len_of;
    input [7:0] a;
    begin
      case (a)
        8'h00: len_of = 3'h4;
        8'h11, 8'h12, 8'h14, 8'h1B, 8'h1D, 8'h1E: len_of = 3'h3;
        8'h13, 8'h15, 8'h16, 8'h18: len_of = 3'h5;
        8'h17: len_of = 3'h7;
        8'h19, 8'h1A, 8'h1C, 8'h20, 8'h40: len_of = 3'h2;
        8'h1F, 8'h22, 8'h23, 8'h24, 8'h25: len_of = 3'h4;
        default: len_of = 3'h1;
      endcase
    end
  endfunction

  // Data byte after the flag byte; axes go Z, Y, X, high byte first
  function [7:0] data_byte;
    input [7:0] a;
    input [2:0] i;
    input [15:0] x;
    input [15:0] y;
    input [15:0] z;
    input [31:0] v;
    reg [47:0] q;
    reg [15:0] w;
    reg [2:0] j;
    reg [1:0] pos;
    begin
      // Selected axes stacked from the top, so Z lands first, then Y, then X
      q = 48'h000000000000;
      if (a[0])
        q = {x, 32'h00000000};
      if (a[1])
        q = {y, q[47:16]};
      if (a[2])
        q = {z, q[47:16]};
      j = i - 3'h1;
      // Upper-byte-only addresses send one byte per axis
      pos = a[3] ? j[1:0] : j[2:1];
      case (pos)
        2'h0: w = q[47:32];
        2'h1: w = q[31:16];
        default: w = q[15:0];
      endcase
      if (a == `MSS_ADDR_SUM)
      begin
        case (j[1:0])
          2'h0: data_byte = v[31:24];
          2'h1: data_byte = v[23:16];
          2'h2: data_byte = v[15:8];
          default: data_byte = v[7:0];
        endcase
      end
      else if (a[3] || !j[0])
        data_byte = w[15:8];
      else
        data_byte = w[7:0];
    end
  endfunction

  // Region decode for the current pointer
  assign in_set = (ptr >= `MSS_ADDR_IRQCFG) && (ptr <= `MSS_ADDR_SET_LAST);
  assign in_data = (ptr > `MSS_ADDR_FLAG) && (ptr <= `MSS_ADDR_DATA_LAST);
  assign cur_len = len_of(ptr);
  assign step = (rd_req_i || wr_req_i) && !acc_start_i;
  assign last_byte = (idx == (cur_len - 3'h1));
  assign data_read_done = rd_req_i && !acc_start_i && in_data && last_byte;
  assign set_touch = (acc_start_i && (acc_addr_i >= `MSS_ADDR_IRQCFG)
    && (acc_addr_i <= `MSS_ADDR_SET_LAST)) || (step && in_set);
  // Level slot: 22h..25h map to pairs 0..3, operate word then release word
  assign thr_sel = {ptr[1:0] - 2'h2, idx[1]};
  // Constant words named so that only whole bytes are ever sliced out
  assign rsv_word = `MSS_RSV_VALUE;
  assign irq_mask = `MSS_IRQCFG_MASK;

  // Flag byte assembly, bit 7 fixed high
  assign flag_byte = {1'b1, ovr_flag, err_flag, sw_sum, sw_z, sw_y, sw_x, rdy_flag};

  // Read data multiplexer
  always @*
  begin
    next_byte = 8'h00;
    if (idx >= cur_len)
      next_byte = 8'h00;
    else if (ptr == `MSS_ADDR_ID)
    begin
      case (idx[1:0])
        2'h0: next_byte = MAKER_CODE;
        2'h1: next_byte = DEV_CODE;
        2'h2: next_byte = rsv_word[15:8];
        default: next_byte = rsv_word[7:0];
      endcase
    end
    else if ((ptr >= `MSS_ADDR_FLAG) && (ptr <= `MSS_ADDR_DATA_LAST))
    begin
      if (idx == 3'h0)
        next_byte = flag_byte;
      else
        next_byte = data_byte(ptr, idx, x_data, y_data, z_data, sum_data);
    end
    else if (ptr == `MSS_ADDR_IRQCFG)
      next_byte = idx[0] ? irq_cfg[7:0] : irq_cfg[15:8];
    else if (ptr == `MSS_ADDR_OPCFG)
      next_byte = op_cfg_o;
    else if (in_set)
      next_byte = idx[0] ? thr[thr_sel[2:0]][7:0] : thr[thr_sel[2:0]][15:8];
    // Soft reset and factory registers read as zero
  end

  // Address pointer and byte index with wrap in the setting range
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ptr <= 8'h00;
      idx <= 3'h0;
    end
    else if (ce_i)
    begin
      if (acc_start_i)
      begin
        ptr <= acc_addr_i;
        idx <= 3'h0;
      end
      else if (step)
      begin
        if (last_byte && in_set)
        begin
          ptr <= (ptr == `MSS_ADDR_SET_LAST) ? `MSS_ADDR_IRQCFG : ptr + 8'h01;
          idx <= 3'h0;
        end
        else if (idx != `MSS_IDX_MAX)
          idx <= idx + 3'h1;
      end
    end
  end

  // Read answer, one cycle after the request
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
    end
    else if (ce_i)
    begin
      rd_valid_o <= rd_req_i && !acc_start_i;
      if (rd_req_i && !acc_start_i)
        rd_data_o <= next_byte;
    end
  end

  // Host writes into configuration, levels and soft reset
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      irq_cfg <= `MSS_IRQCFG_RESET;
      op_cfg_o <= `MSS_OPCFG_RESET;
      soft_reset_byte_o <= 1'b0;
      for (k = 0; k < 8; k = k + 1)
        thr[k] <= `MSS_THR_RESET;
    end
    else if (ce_i)
    begin
      soft_reset_byte_o <= 1'b0;
      if (soft_reset_byte_o)
      begin
        // Soft reset returns settings to their power-on values
        irq_cfg <= `MSS_IRQCFG_RESET;
        op_cfg_o <= `MSS_OPCFG_RESET;
        for (k = 0; k < 8; k = k + 1)
          thr[k] <= `MSS_THR_RESET;
      end
      else if (wr_req_i && !acc_start_i && (idx < cur_len))
      begin
        if (ptr == `MSS_ADDR_IRQCFG)
        begin
          if (idx[0])
            irq_cfg[7:0] <= wr_data_i & irq_mask[7:0];
          else
            irq_cfg[15:8] <= wr_data_i & irq_mask[15:8];
        end
        else if (ptr == `MSS_ADDR_OPCFG)
          op_cfg_o <= wr_data_i;
        else if (in_set)
        begin
          if (idx[0])
            thr[thr_sel[2:0]][7:0] <= wr_data_i;
          else
            thr[thr_sel[2:0]][15:8] <= wr_data_i;
        end
        else if (ptr == `MSS_ADDR_SOFT_RESET_BYTE)
          soft_reset_byte_o <= wr_data_i[`MSS_SOFT_RESET_BYTE_BIT];
        // Factory registers ignore writes
      end
    end
  end

  // Result capture and overflow flag
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      x_data <= 16'h0000;
      y_data <= 16'h0000;
      z_data <= 16'h0000;
      sum_data <= 32'h00000000;
      err_flag <= 1'b0;
    end
    else if (ce_i)
    begin
      if (soft_reset_byte_o)
        err_flag <= 1'b0;
      else if (meas_done_i)
      begin
        x_data <= meas_x_i;
        y_data <= meas_y_i;
        z_data <= meas_z_i;
        sum_data <= meas_sum_i;
        err_flag <= meas_ovf_i;
      end
    end
  end

  // Data ready and overrun; a new result wins over a read or setting clear, a soft reset wins over a new result
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdy_flag <= 1'b0;
      ovr_flag <= 1'b0;
      read_seen <= 1'b0;
    end
    else if (ce_i)
    begin
      if (soft_reset_byte_o)
      begin
        rdy_flag <= 1'b0;
        ovr_flag <= 1'b0;
        read_seen <= 1'b0;
      end
      else
      begin
        if (meas_done_i)
          rdy_flag <= 1'b1;
        else if (data_read_done || set_touch)
          rdy_flag <= 1'b0;
        // Unread result being replaced marks an overrun
        if (meas_done_i && rdy_flag && !data_read_done)
          ovr_flag <= 1'b1;
        else if (meas_done_i && read_seen)
          ovr_flag <= 1'b0;
        // Read seen before the next result is needed to drop overrun
        if (data_read_done)
          read_seen <= 1'b1;
        else if (meas_done_i)
          read_seen <= 1'b0;
      end
    end
  end

  // Four hysteresis switches share one module
  mss_hyst u_hyst_x (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .clr_i(soft_reset_byte_o),
    .upd_i(meas_done_i), .sgn_i(1'b1), .pol_i(irq_cfg[`MSS_POL_X]), .op_lvl_i(thr[0]),
    .rel_lvl_i(thr[1]), .val_i({16'h0000, meas_x_i}), .flag_o(sw_x));
  mss_hyst u_hyst_y (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .clr_i(soft_reset_byte_o),
    .upd_i(meas_done_i), .sgn_i(1'b1), .pol_i(irq_cfg[`MSS_POL_Y]), .op_lvl_i(thr[2]),
    .rel_lvl_i(thr[3]), .val_i({16'h0000, meas_y_i}), .flag_o(sw_y));
  mss_hyst u_hyst_z (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .clr_i(soft_reset_byte_o),
    .upd_i(meas_done_i), .sgn_i(1'b1), .pol_i(irq_cfg[`MSS_POL_Z]), .op_lvl_i(thr[4]),
    .rel_lvl_i(thr[5]), .val_i({16'h0000, meas_z_i}), .flag_o(sw_z));
  mss_hyst u_hyst_sum (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .clr_i(soft_reset_byte_o),
    .upd_i(meas_done_i), .sgn_i(1'b0), .pol_i(irq_cfg[`MSS_POL_SUM]), .op_lvl_i(thr[6]),
    .rel_lvl_i(thr[7]), .val_i(meas_sum_i), .flag_o(sw_sum));

  // Event output registered so the pin never glitches
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      evt_o <= 1'b0;
    else if (ce_i)
      evt_o <= |(flag_byte[`MSS_IRQ_EN_MSB:0] & irq_cfg[`MSS_IRQ_EN_MSB:0]);
  end

endmodule

`default_nettype wire

// ### tb/mss_meas_model.sv
// Behavioural measurement engine feeding results to the bank
`timescale 1ns/10ps
`default_nettype none
module mss_meas_model (
  // Clock
  input wire logic mclk_i,
  // Results
  output logic meas_done_o,
  output logic meas_ovf_o,
  output logic [15:0] meas_x_o,
  output logic [15:0] meas_y_o,
  output logic [15:0] meas_z_o,
  output logic [31:0] meas_sum_o
);
  // Idle lines at time zero
  initial
  begin
    meas_done_o = 1'b0;
    meas_ovf_o = 1'b0;
    {meas_x_o, meas_y_o, meas_z_o, meas_sum_o} = 80'h0;
  end

  // One-cycle result; lines show junk afterwards so stale reads show up
  task fire(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z,
            input logic [31:0] s, input logic o);
  begin
    {meas_x_o, meas_y_o, meas_z_o, meas_sum_o, meas_ovf_o} = {x, y, z, s, o};
    meas_done_o = 1'b1;
    @(negedge mclk_i);
    meas_done_o = 1'b0;
    {meas_x_o, meas_y_o, meas_z_o, meas_sum_o, meas_ovf_o} = ~{x, y, z, s, o};
  end
  endtask
endmodule
`default_nettype wire

// ### tb/mss_regbank_properties.sv
// Port-level checker for the switch sensor register bank
`timescale 1ns/10ps
`default_nettype none
module mss_regbank_properties #(
  parameter [7:0] DEV_CODE = 8'h5A, // Arbitrary value
  parameter [7:0] MAKER_CODE = 8'hA5 // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Host access
  input wire logic acc_start_i,
  input wire logic [7:0] acc_addr_i,
  input wire logic rd_req_i,
  // Measurement results
  input wire logic meas_done_i,
  input wire logic meas_ovf_i,
  // Answers
  input wire logic rd_valid_o,
  input wire logic [7:0] rd_data_o,
  input wire logic soft_reset_byte_o
);
  reg [7:0] adr;
  reg [2:0] idx;
  reg seen;
  reg last_ovf;
  wire rd_take = rd_req_i && !acc_start_i && ce_i;
  wire flag_rd = rd_take && adr[7:4] == 4'h1 && idx == 3'h0;

  // Shadow of access position and of the last result; index saturates like the bank
  always @(posedge mclk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      adr <= 8'h00;
      idx <= 3'h0;
      seen <= 1'b0;
      last_ovf <= 1'b0;
    end
    else if (ce_i)
    begin
      if (acc_start_i)
        adr <= acc_addr_i;
      if (acc_start_i)
        idx <= 3'h0;
      else if (rd_req_i && idx != 3'h7)
        idx <= idx + 3'h1;
      if (soft_reset_byte_o)
        seen <= 1'b0;
      else if (meas_done_i)
        seen <= 1'b1;
      if (soft_reset_byte_o)
        last_ovf <= 1'b0;
      else if (meas_done_i)
        last_ovf <= meas_ovf_i;
    end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // New result followed at once by a flag-byte read
  sequence s_new_data;
    meas_done_i && ce_i ##1 ce_i && acc_start_i && acc_addr_i[7:4] == 4'h1 && !meas_done_i;
  endsequence
  // Setting register touched, one idle cycle, then flag byte addressed
  sequence s_set_acc;
    ce_i && acc_start_i && acc_addr_i >= 8'h20 && acc_addr_i <= 8'h25 && !meas_done_i
    ##1 !meas_done_i ##1 ce_i && acc_start_i && acc_addr_i[7:4] == 4'h1 && !meas_done_i;
  endsequence

  a_read_answer: assert property (rd_take |=> rd_valid_o)
    else $error("read byte not answered");
  a_valid_cause: assert property (rd_valid_o |-> $past(rd_take) || !$past(ce_i))
    else $error("read byte without request");
  a_data_holds: assert property (!rd_valid_o |-> $stable(rd_data_o))
    else $error("read data moved");
  a_maker_byte: assert property (rd_take && adr == 8'h00 && idx == 3'h0 |=> rd_data_o == MAKER_CODE)
    else $error("maker byte wrong");
  a_device_byte: assert property (rd_take && adr == 8'h00 && idx == 3'h1 |=> rd_data_o == DEV_CODE)
    else $error("device byte wrong");
  a_flag_top: assert property (flag_rd |=> rd_data_o[7])
    else $error("flag byte bit 7 low");
  a_flag_reset: assert property (flag_rd && !seen |=> rd_data_o == 8'h80)
    else $error("idle flag byte wrong");
  a_overflow_bit: assert property (flag_rd |=> rd_data_o[5] == $past(last_ovf))
    else $error("overflow bit wrong");
  a_ready_set: assert property (s_new_data ##1 rd_take |=> rd_data_o[0])
    else $error("data ready not set");
  a_ready_clear: assert property (s_set_acc ##1 rd_take |=> !rd_data_o[0])
    else $error("data ready not cleared");
endmodule

bind mss_regbank mss_regbank_properties #(.DEV_CODE(DEV_CODE), .MAKER_CODE(MAKER_CODE)) u_props (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .acc_start_i(acc_start_i),
  .acc_addr_i(acc_addr_i),
  .rd_req_i(rd_req_i), .meas_done_i(meas_done_i), .meas_ovf_i(meas_ovf_i),
  .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .soft_reset_byte_o(soft_reset_byte_o));
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the switch sensor register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam [7:0] DEV = 8'h3C; // Arbitrary value
  localparam [7:0] MAKER = 8'hC3; // Arbitrary value
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic acc_start_i = 1'b0;
  logic [7:0] acc_addr_i = 8'h00;
  logic rd_req_i = 1'b0;
  logic wr_req_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00;
  wire meas_done_i, meas_ovf_i, rd_valid_o, soft_reset_byte_o, evt_o;
  wire [15:0] meas_x_i, meas_y_i, meas_z_i;
  wire [31:0] meas_sum_i;
  wire [7:0] rd_data_o, op_cfg_o;
  int mismatches = 0;
  int n_tests = 0;
  int i;
  logic [15:0] exp_q[$];
  logic [15:0] ent, rx, ry, rz;
  logic [31:0] rs;
  logic [7:0] r8;
  logic [15:0] hx[3] = '{16'h0200, 16'h00C0, 16'h0040};
  logic [7:0] he[3] = '{8'h02, 8'h02, 8'h00};

  always #20 mclk_i = ~mclk_i;

  mss_regbank #(.DEV_CODE(DEV), .MAKER_CODE(MAKER)) DUT (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .acc_start_i(acc_start_i),
    .acc_addr_i(acc_addr_i), .rd_req_i(rd_req_i), .wr_req_i(wr_req_i), .wr_data_i(wr_data_i),
    .meas_done_i(meas_done_i), .meas_ovf_i(meas_ovf_i), .meas_x_i(meas_x_i),
    .meas_y_i(meas_y_i), .meas_z_i(meas_z_i), .meas_sum_i(meas_sum_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .op_cfg_o(op_cfg_o),
    .soft_reset_byte_o(soft_reset_byte_o), .evt_o(evt_o));

  mss_meas_model PART (
    .mclk_i(mclk_i), .meas_done_o(meas_done_i), .meas_ovf_o(meas_ovf_i),
    .meas_x_o(meas_x_i), .meas_y_o(meas_y_i), .meas_z_o(meas_z_i), .meas_sum_o(meas_sum_i));

  // Byte compare; automatic since monitor and sequence may both call it
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
  begin
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask

  // Host access strobes, each held over one sampling edge
  task st(input logic [7:0] a);
  begin
    acc_start_i = 1'b1;
    acc_addr_i = a;
    @(negedge mclk_i);
    acc_start_i = 1'b0;
  end
  endtask

  task automatic rd(input logic [7:0] e, input logic [7:0] m = 8'hFF);
  begin
    exp_q.push_back({m, e});
    rd_req_i = 1'b1;
    @(negedge mclk_i);
    rd_req_i = 1'b0;
    @(negedge mclk_i);
  end
  endtask

  task wr(input logic [7:0] d);
  begin
    wr_data_i = d;
    wr_req_i = 1'b1;
    @(negedge mclk_i);
    wr_req_i = 1'b0;
    @(negedge mclk_i);
  end
  endtask

  // Each answered byte takes the oldest note
  always @(negedge mclk_i)
    if (rd_valid_o === 1'b1)
    begin
      // An answer nobody asked for is a fault too
      if (exp_q.size() == 0)
        mismatches++;
      else
      begin
        ent = exp_q.pop_front();
        chk8(rd_data_o & ent[15:8], ent[7:0] & ent[15:8]);
      end
    end

  task close_out;
  begin
    if (exp_q.size() != 0)
      mismatches++;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  // Watchdog, far beyond the 164 cycles the sequence needs
  initial
  begin
    #200000;
    mismatches++;
    close_out;
  end

  // Main sequence; factory test addresses are never touched
  initial
  begin
    void'($urandom(32'h3338e995));
    repeat (10) @(negedge mclk_i);
    nrst_i = 1'b1;
    @(negedge mclk_i);
    st(8'h00);
    rd(MAKER);
    rd(DEV);
    for (i = 0; i < 3; i++) rd(8'h00);
    st(8'h50);
    rd(8'h00);
    st(8'h10);
    rd(8'h80);
    // Random signs fixed so switch flags are known with zero levels
    rx = {1'b0, 15'($urandom)} | 16'h0001;
    ry = {1'b1, 15'($urandom)};
    rz = {1'b0, 15'($urandom)} | 16'h0001;
    rs = $urandom | 32'h1;
    PART.fire(rx, ry, rz, rs, 1'b0);
    st(8'h17);
    rd(8'h9B);
    rd(rz[15:8]);
    rd(rz[7:0]);
    rd(ry[15:8]);
    rd(ry[7:0]);
    rd(rx[15:8]);
    rd(rx[7:0]);
    st(8'h10);
    rd(8'h9A);
    PART.fire(16'h1234, 16'h1234, 16'h1234, 32'h89ABCDEF, 1'b1);
    @(negedge mclk_i);
    PART.fire(16'h1234, 16'h1234, 16'h1234, 32'h89ABCDEF, 1'b1);
    st(8'h18);
    rd(8'hFF);
    rd(8'h89);
    rd(8'hAB);
    rd(8'hCD);
    rd(8'hEF);
    st(8'h10);
    rd(8'hFE);
    PART.fire(16'h1234, 16'h1234, 16'h1234, 32'h89ABCDEF, 1'b0);
    st(8'h10);
    rd(8'h9F);
    PART.fire(16'h1101, 16'h2202, 16'h3303, 32'h89ABCDEF, 1'b0);
    st(8'h10);
    rd(8'hDF);
    // Upper-byte-only burst: Z, Y, X high bytes
    st(8'h1F);
    rd(8'hDF);
    rd(8'h33);
    rd(8'h22);
    rd(8'h11);
    st(8'h25);
    for (i = 0; i < 4; i++) wr(8'h00);
    wr(8'hF0);
    wr(8'h01);
    st(8'h20);
    // Idle cycle so the start strobe is never lowered and raised in one step
    @(negedge mclk_i);
    st(8'h10);
    rd(8'h00, 8'h01);
    st(8'h20);
    rd(8'h00);
    rd(8'h01);
    chk1(evt_o, 1'b0);
    PART.fire(rx, ry, rz, rs, 1'b0);
    repeat (3) @(negedge mclk_i);
    chk1(evt_o, 1'b1);
    st(8'h22);
    wr(8'h01);
    wr(8'h00);
    wr(8'h00);
    wr(8'h80);
    for (i = 0; i < 3; i++)
    begin
      PART.fire(hx[i], 16'h0000, 16'h0000, 32'h0, 1'b0);
      st(8'h10);
      rd(he[i], 8'h02);
    end
    // Mirrored X switch with its event enabled
    st(8'h20);
    wr(8'h01);
    wr(8'h02);
    PART.fire(16'h0040, 16'h0000, 16'h0000, 32'h0, 1'b0);
    repeat (2) @(negedge mclk_i);
    chk1(evt_o, 1'b1);
    st(8'h10);
    rd(8'h02, 8'h02);
    PART.fire(16'h0200, 16'h0000, 16'h0000, 32'h0, 1'b0);
    st(8'h10);
    rd(8'h00, 8'h02);
    chk1(evt_o, 1'b0);
    r8 = 8'($urandom);
    st(8'h21);
    wr(r8);
    chk8(op_cfg_o, r8);
    st(8'h30);
    wr_data_i = 8'h01;
    wr_req_i = 1'b1;
    @(negedge mclk_i);
    wr_req_i = 1'b0;
    chk1(soft_reset_byte_o, 1'b1);
    @(negedge mclk_i);
    chk1(soft_reset_byte_o, 1'b0);
    repeat (2) @(negedge mclk_i);
    st(8'h10);
    rd(8'h80);
    st(8'h20);
    rd(8'h00);
    rd(8'h00);
    // Frozen clock enable: a result offered now must leave no trace
    ce_i = 1'b0;
    PART.fire(rx, ry, rz, rs, 1'b1);
    ce_i = 1'b1;
    st(8'h10);
    rd(8'h80);
    close_out;
  end
endmodule
`default_nettype wire
